// File: src/ilr_cfg.svh
// Purpose: address map, reset values and sizes for the line control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
`ifndef ILR_CFG_SVH
`define ILR_CFG_SVH

`define ILR_ADDR_W        8
`define ILR_OFF_IRQ_EN    8'h00
`define ILR_OFF_IRQ_DIS   8'h04
`define ILR_OFF_IRQ_MASK  8'h08
`define ILR_OFF_IRQ_STAT  8'h0c
`define ILR_OFF_OD_EN     8'h10
`define ILR_OFF_OD_DIS    8'h14
`define ILR_OFF_OD_STAT   8'h18
`define ILR_OFF_PU_DIS    8'h20
`define ILR_OFF_PU_EN     8'h24
`define ILR_OFF_PU_STAT   8'h28
`define ILR_OFF_PA_SEL    8'h30
`define ILR_OFF_PA_STAT   8'h34
`define ILR_RST_MASK      32'h0000_0000
`define ILR_RST_OD        32'h0000_0000
`define ILR_RST_PU_ON     32'hffff_ffff
`define ILR_RST_PA        32'hffff_ffff
`define ILR_ZERO          32'h0000_0000

`endif

// File: src/ilr_pkg.sv
// Purpose: shared types of the line control block
// Assumes: 32 lines
// Notes:   the bus request travels as one struct
package ilr_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic        rd;
        logic [31:0] wdata;
    } ilr_req_t;

    typedef enum logic [0:0] {
        ILR_IDLE   = 1'b0,
        ILR_ACCESS = 1'b1
    } ilr_phase_t;

endpackage

// File: src/ilr_pad.sv
// Purpose: per-line pin drive stage
// Assumes: output enable low means the pin is driven
// Notes:   open-drain lines only ever pull low
`timescale 1ns/1ps
module ilr_pad #(
    parameter int LINES = 32
) (
    // control
    input  wire logic [LINES-1:0] open_drain,
    input  wire logic [LINES-1:0] drive_req,
    input  wire logic [LINES-1:0] drive_val,
    // pin
    output wire logic [LINES-1:0] pin_out,
    output wire logic [LINES-1:0] pin_oe_n
);

    genvar g;
    generate
        for (g = 0; g < LINES; g++)
        begin : g_line
            // open-drain: drive only low, release for high
            assign pin_out[g]  = open_drain[g] ? 1'b0 : drive_val[g];
            assign pin_oe_n[g] = ~(drive_req[g] &
                                   (~open_drain[g] | ~drive_val[g]));
        end
    endgenerate

endmodule

// File: src/ilr_regs.sv
// Purpose: per-line change detect, open-drain, pull-up, peripheral A regs
// Assumes: pin inputs synchronous to pclk; APB slave, zero wait states
// Notes:   status read clears; a change in the read cycle is kept
`include "ilr_cfg.svh"
`timescale 1ns/1ps
module ilr_regs #(
    parameter int LINES = 32
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output wire logic             pready,
    output wire logic             pslverr,
    // lines
    input  wire logic [LINES-1:0] pin_in,
    input  wire logic [LINES-1:0] line_drive_req,
    input  wire logic [LINES-1:0] line_drive_val,
    output wire logic [LINES-1:0] pin_out,
    output wire logic [LINES-1:0] pin_oe_n,
    output wire logic [LINES-1:0] pullup_on,
    output wire logic [LINES-1:0] periph_a_sel,
    // interrupt
    output wire logic             change_irq
);

    // ************************************************************
    // parameter check
    // ************************************************************
    if (LINES < 1 || LINES > 32)
    begin : g_lines_check
        $error("LINES must lie between 1 and 32");
    end

    // ************************************************************
    // bus decode
    // ************************************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    ilr_pkg::ilr_req_t req;
    ilr_pkg::ilr_phase_t phase;
    assign req.addr  = paddr;
    assign req.wdata = pwdata;
    assign req.wr    = psel & penable & pwrite;
    assign req.rd    = psel & penable & ~pwrite;
    assign phase     = (psel & penable) ? ilr_pkg::ILR_ACCESS
                                        : ilr_pkg::ILR_IDLE;

    wire logic [LINES-1:0] wbits = req.wdata[LINES-1:0];
    wire logic wr_irq_en  = req.wr & hit(req.addr, `ILR_OFF_IRQ_EN);
    wire logic wr_irq_dis = req.wr & hit(req.addr, `ILR_OFF_IRQ_DIS);
    wire logic wr_od_en   = req.wr & hit(req.addr, `ILR_OFF_OD_EN);
    wire logic wr_od_dis  = req.wr & hit(req.addr, `ILR_OFF_OD_DIS);
    wire logic wr_pu_dis  = req.wr & hit(req.addr, `ILR_OFF_PU_DIS);
    wire logic wr_pu_en   = req.wr & hit(req.addr, `ILR_OFF_PU_EN);
    wire logic wr_pa_sel  = req.wr & hit(req.addr, `ILR_OFF_PA_SEL);
    wire logic rd_stat    = req.rd & hit(req.addr, `ILR_OFF_IRQ_STAT);

    wire logic known = hit(req.addr, `ILR_OFF_IRQ_EN)
                     | hit(req.addr, `ILR_OFF_IRQ_DIS)
                     | hit(req.addr, `ILR_OFF_IRQ_MASK)
                     | hit(req.addr, `ILR_OFF_IRQ_STAT)
                     | hit(req.addr, `ILR_OFF_OD_EN)
                     | hit(req.addr, `ILR_OFF_OD_DIS)
                     | hit(req.addr, `ILR_OFF_OD_STAT)
                     | hit(req.addr, `ILR_OFF_PU_DIS)
                     | hit(req.addr, `ILR_OFF_PU_EN)
                     | hit(req.addr, `ILR_OFF_PU_STAT)
                     | hit(req.addr, `ILR_OFF_PA_SEL)
                     | hit(req.addr, `ILR_OFF_PA_STAT);

    assign pready  = 1'b1;
    // unmapped access answers with an error, no effect
    assign pslverr = (phase == ilr_pkg::ILR_ACCESS) & ~known;

    // ************************************************************
    // control state
    // ************************************************************
    logic [LINES-1:0] irq_mask;
    logic [LINES-1:0] irq_stat;
    logic [LINES-1:0] od_mode;
    logic [LINES-1:0] pu_on;
    logic [LINES-1:0] pa_route;
    logic [LINES-1:0] pin_prev;

    // enable and disable together: disable wins, safer for a handler
    wire logic [LINES-1:0] next_irq_mask =
        (irq_mask | (wr_irq_en ? wbits : '0))
        & ~(wr_irq_dis ? wbits : '0);
    wire logic [LINES-1:0] next_od_mode =
        (od_mode | (wr_od_en ? wbits : '0))
        & ~(wr_od_dis ? wbits : '0);
    wire logic [LINES-1:0] next_pu_on =
        (pu_on | (wr_pu_en ? wbits : '0))
        & ~(wr_pu_dis ? wbits : '0);
    wire logic [LINES-1:0] next_pa_route =
        pa_route | (wr_pa_sel ? wbits : '0);

    // only bits already shown in prdata are cleared; a change seen
    // after the setup-cycle load waits for the next read: set wins
    wire logic [LINES-1:0] change = pin_in ^ pin_prev;
    wire logic [LINES-1:0] seen_bits =
        rd_stat ? prdata[LINES-1:0] : '0;
    wire logic [LINES-1:0] next_irq_stat =
        (irq_stat & ~seen_bits) | change;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_mask <= LINES'(`ILR_RST_MASK);
            irq_stat <= LINES'(`ILR_ZERO);
            od_mode  <= LINES'(`ILR_RST_OD);
            pu_on    <= LINES'(`ILR_RST_PU_ON);
            pa_route <= LINES'(`ILR_RST_PA);
            pin_prev <= LINES'(`ILR_ZERO);
        end
        else
        begin
            irq_mask <= next_irq_mask;
            irq_stat <= next_irq_stat;
            od_mode  <= next_od_mode;
            pu_on    <= next_pu_on;
            pa_route <= next_pa_route;
            pin_prev <= pin_in;
        end
    end

    // pin_prev is zero at reset, so a line high at release flags once
    // ************************************************************
    // read mux
    // ************************************************************
    function automatic logic [31:0] widen(input logic [LINES-1:0] v);
        widen = `ILR_ZERO;
        widen[LINES-1:0] = v;
    endfunction

    logic [31:0] next_prdata;
    always_comb
    begin
        next_prdata = `ILR_ZERO;
        case (req.addr)
            `ILR_OFF_IRQ_MASK: next_prdata = widen(irq_mask);
            `ILR_OFF_IRQ_STAT: next_prdata = widen(irq_stat);
            `ILR_OFF_OD_STAT:  next_prdata = widen(od_mode);
            `ILR_OFF_PU_STAT:  next_prdata = widen(~pu_on);
            `ILR_OFF_PA_STAT:  next_prdata = widen(pa_route);
            default:           next_prdata = `ILR_ZERO;
        endcase
    end

    // data from a flop, loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= `ILR_ZERO;
        else if (psel & ~penable & ~pwrite)
            prdata <= next_prdata;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign pullup_on    = pu_on;
    assign periph_a_sel = pa_route;
    assign change_irq   = |(irq_stat & irq_mask);

    ilr_pad #(
        .LINES (LINES)
    ) u_pad (
        .open_drain (od_mode),
        .drive_req  (line_drive_req),
        .drive_val  (line_drive_val),
        .pin_out    (pin_out),
        .pin_oe_n   (pin_oe_n)
    );

    // ************************************************************
    // assertions
    // ************************************************************
    a_mask_enable:
        assert property (@(posedge pclk) disable iff (!presetn)
            wr_irq_en && !wr_irq_dis
            |=> (irq_mask & $past(wbits)) == $past(wbits))
        else $error("enable write did not set mask");

    a_mask_disable:
        assert property (@(posedge pclk) disable iff (!presetn)
            wr_irq_dis
            |=> (irq_mask & $past(wbits)) == '0)
        else $error("disable write did not clear mask");

    a_mask_hold:
        assert property (@(posedge pclk) disable iff (!presetn)
            !wr_irq_en && !wr_irq_dis
            |=> irq_mask == $past(irq_mask))
        else $error("mask changed without write");

    a_mask_read:
        assert property (@(posedge pclk) disable iff (!presetn)
            psel && !penable && !pwrite && paddr == `ILR_OFF_IRQ_MASK
            |=> prdata[LINES-1:0] == $past(irq_mask))
        else $error("mask read does not show enabled lines");

    a_stat_set:
        assert property (@(posedge pclk) disable iff (!presetn)
            |change
            |=> (irq_stat & $past(change)) == $past(change))
        else $error("change not recorded");

    a_stat_clear:
        assert property (@(posedge pclk) disable iff (!presetn)
            rd_stat
            |=> (irq_stat & $past(prdata[LINES-1:0] & ~change)) == '0)
        else $error("status read did not clear");

    a_stat_keep:
        assert property (@(posedge pclk) disable iff (!presetn)
            rd_stat |=> (irq_stat & $past(irq_stat & ~prdata[LINES-1:0]))
                        == $past(irq_stat & ~prdata[LINES-1:0]))
        else $error("unreported change lost by status read");

    a_stat_hold:
        assert property (@(posedge pclk) disable iff (!presetn)
            !rd_stat && !(|change)
            |=> irq_stat == $past(irq_stat))
        else $error("status changed with no event");

    a_stat_read:
        assert property (@(posedge pclk) disable iff (!presetn)
            psel && !penable && !pwrite && paddr == `ILR_OFF_IRQ_STAT
            |=> prdata[LINES-1:0] == $past(irq_stat))
        else $error("status read shows wrong lines");

    a_od_enable:
        assert property (@(posedge pclk) disable iff (!presetn)
            wr_od_en && !wr_od_dis
            |=> (od_mode & $past(wbits)) == $past(wbits))
        else $error("open-drain enable failed");

    a_od_disable:
        assert property (@(posedge pclk) disable iff (!presetn)
            wr_od_dis
            |=> (od_mode & $past(wbits)) == '0)
        else $error("open-drain disable failed");

    a_od_hold:
        assert property (@(posedge pclk) disable iff (!presetn)
            !wr_od_en && !wr_od_dis
            |=> od_mode == $past(od_mode))
        else $error("open-drain mode changed without write");

    a_od_no_high:
        assert property (@(posedge pclk) disable iff (!presetn)
            (od_mode & ~pin_oe_n & pin_out)
            == '0)
        else $error("open-drain line driven high");

    a_push_pull:
        assert property (@(posedge pclk) disable iff (!presetn)
            (~od_mode & line_drive_req & pin_oe_n)
            == '0)
        else $error("normal line not driven");

    a_od_read:
        assert property (@(posedge pclk) disable iff (!presetn)
            psel && !penable && !pwrite && paddr == `ILR_OFF_OD_STAT
            |=> prdata[LINES-1:0] == $past(od_mode))
        else $error("open-drain status read wrong");

    a_pu_pair:
        assert property (@(posedge pclk) disable iff (!presetn)
            wr_pu_dis
            |=> (pu_on & $past(wbits)) == '0)
        else $error("pull-up disable failed");

    a_pu_enable:
        assert property (@(posedge pclk) disable iff (!presetn)
            wr_pu_en && !wr_pu_dis
            |=> (pu_on & $past(wbits)) == $past(wbits))
        else $error("pull-up enable failed");

    a_pu_hold:
        assert property (@(posedge pclk) disable iff (!presetn)
            !wr_pu_en && !wr_pu_dis
            |=> pu_on == $past(pu_on))
        else $error("pull-up changed without write");

    a_pu_read:
        assert property (@(posedge pclk) disable iff (!presetn)
            psel && !penable && !pwrite && paddr == `ILR_OFF_PU_STAT
            |=> prdata[LINES-1:0] == ~$past(pu_on))
        else $error("pull-up status not inverted");

    a_pa_select:
        assert property (@(posedge pclk) disable iff (!presetn)
            wr_pa_sel
            |=> (pa_route & $past(wbits)) == $past(wbits))
        else $error("peripheral A select failed");

    a_pa_keep:
        assert property (@(posedge pclk) disable iff (!presetn)
            !wr_pa_sel
            |=> pa_route == $past(pa_route))
        else $error("routing changed without write");

    a_irq_raise:
        assert property (@(posedge pclk) disable iff (!presetn)
            |(change & irq_mask) && !wr_irq_dis
            |=> change_irq)
        else $error("enabled change did not raise interrupt");

    a_irq_clear:
        assert property (@(posedge pclk) disable iff (!presetn)
            rd_stat && !(|change) && (irq_stat & ~prdata[LINES-1:0]) == '0
            |=> !change_irq)
        else $error("interrupt stayed high after status read");

    a_irq_quiet:
        assert property (@(posedge pclk) disable iff (!presetn)
            irq_mask == '0
            |-> !change_irq)
        else $error("interrupt high with all lines masked");

    a_wo_read:
        assert property (@(posedge pclk) disable iff (!presetn)
            psel && !penable && !pwrite && paddr == `ILR_OFF_IRQ_EN
            |=> prdata == `ILR_ZERO)
        else $error("write-only register read not zero");

    a_prdata_hold:
        assert property (@(posedge pclk) disable iff (!presetn)
            !(psel && !penable && !pwrite)
            |=> prdata == $past(prdata))
        else $error("read data changed outside a read");

endmodule

// File: verif/ilr_pin_model.sv
// Purpose: pins of the 32 lines and the far-side drivers on them
// Assumes: far-side drivers change just after a pclk edge
// Notes:   a line nobody drives and without pull-up toggles every cycle
`timescale 1ns/1ps
module ilr_pin_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // design side
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe_n,
    input  wire logic [31:0] pullup_on,
    // far-side drivers
    input  wire logic [31:0] ext_en,
    input  wire logic [31:0] ext_val,
    // resolved level
    output wire logic [31:0] pin_in
);
    logic [31:0] last;
    wire  logic [31:0] low_drv;
    wire  logic [31:0] high_drv;

    assign low_drv  = (~pin_oe_n & ~pin_out) | (ext_en & ~ext_val);
    assign high_drv = (~pin_oe_n & pin_out) | (ext_en & ext_val)
                    | pullup_on;
    // any low driver wins; a floating line must not settle by luck
    assign pin_in   = ~low_drv & (high_drv | ~last);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last <= 32'h0000_0000;
        else
            last <= pin_in;
    end
endmodule

// File: verif/io_line_irq_drive_pullup_regs_test.sv
// Purpose: register-level test of the line control block over apb
// Assumes: zero wait states are not relied on; the master waits for pready
// Notes:   status expectations follow the pin levels the model resolves
`include "ilr_cfg.svh"
`timescale 1ns/1ps
module io_line_irq_drive_pullup_regs_test;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] pin_in;
    logic [31:0] line_drive_req;
    logic [31:0] line_drive_val;
    logic [31:0] pin_out;
    logic [31:0] pin_oe_n;
    logic [31:0] pullup_on;
    logic [31:0] periph_a_sel;
    logic        change_irq;
    logic [31:0] ext_en;
    logic [31:0] ext_val;
    logic [31:0] q;
    logic        e;
    int          err_total = 0;
    int          compares  = 0;

    ilr_regs #(.LINES(32)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .line_drive_req(line_drive_req), .line_drive_val(line_drive_val),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_on(pullup_on),
        .periph_a_sel(periph_a_sel), .change_irq(change_irq));

    ilr_pin_model i_pins (
        .pclk(pclk), .presetn(presetn), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pullup_on(pullup_on), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    always #20 pclk = ~pclk;

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ************************************************************
    // sequence
    // ************************************************************
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        line_drive_req = 32'h0000_0000;
        line_drive_val = 32'h0000_0000;
        ext_en = 32'h0000_0000;
        ext_val = 32'h0000_0000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk(pullup_on, 32'hffff_ffff);
        rd(`ILR_OFF_IRQ_MASK, 32'h0000_0000);
        rd(`ILR_OFF_OD_STAT, 32'h0000_0000);
        rd(`ILR_OFF_PU_STAT, 32'h0000_0000);
        rd(`ILR_OFF_IRQ_STAT, 32'hffff_ffff);
        rd(`ILR_OFF_IRQ_STAT, 32'h0000_0000);
        wr(`ILR_OFF_IRQ_EN, 32'h8000_0001);
        wr(`ILR_OFF_IRQ_EN, 32'h0000_0000);
        rd(`ILR_OFF_IRQ_MASK, 32'h8000_0001);
        wr(`ILR_OFF_IRQ_DIS, 32'h0000_0001);
        rd(`ILR_OFF_IRQ_MASK, 32'h8000_0000);
        // masked-off line changes: status only, no interrupt
        ext_en <= 32'h0000_0001;
        repeat (2) @(posedge pclk);
        chk(change_irq, 1'b0);
        rd(`ILR_OFF_IRQ_STAT, 32'h0000_0001);
        ext_en <= 32'h8000_0001;
        repeat (2) @(posedge pclk);
        chk(change_irq, 1'b1);
        rd(`ILR_OFF_IRQ_STAT, 32'h8000_0000);
        @(posedge pclk);
        chk(change_irq, 1'b0);
        // line 1 falls in the setup cycle: missed now, kept for next read
        fork
            rd(`ILR_OFF_IRQ_STAT, 32'h0000_0000);
            begin
                @(posedge pclk);
                ext_en <= 32'h8000_0003;
            end
        join
        rd(`ILR_OFF_IRQ_STAT, 32'h0000_0002);
        line_drive_req <= 32'h0000_00ff;
        line_drive_val <= 32'h0000_0055;
        wr(`ILR_OFF_OD_EN, 32'h0000_00f0);
        rd(`ILR_OFF_OD_STAT, 32'h0000_00f0);
        chk(pin_oe_n, 32'hffff_ff50);
        chk(pin_out & ~pin_oe_n, 32'h0000_0005);
        wr(`ILR_OFF_OD_DIS, 32'h0000_0030);
        wr(`ILR_OFF_OD_DIS, 32'h0000_0000);
        rd(`ILR_OFF_OD_STAT, 32'h0000_00c0);
        chk(pin_oe_n, 32'hffff_ff40);
        // hold the lines up before their pull-ups go off
        ext_val <= 32'h0000_ff00;
        ext_en  <= 32'h8000_ff01;
        wr(`ILR_OFF_PU_DIS, 32'h0000_ff00);
        rd(`ILR_OFF_PU_STAT, 32'h0000_ff00);
        chk(pullup_on, 32'hffff_00ff);
        wr(`ILR_OFF_PU_EN, 32'h0000_0f00);
        rd(`ILR_OFF_PU_STAT, 32'h0000_f000);
        chk(pullup_on, 32'hffff_0fff);
        wr(`ILR_OFF_PA_SEL, 32'h0000_0001);
        rd(`ILR_OFF_PA_STAT, 32'hffff_ffff);
        chk(periph_a_sel, 32'hffff_ffff);
        rd(8'h1c, 32'h0000_0000);
        chk(e, 1'b1);
        wr(8'h1c, 32'hffff_ffff);
        rd(`ILR_OFF_OD_STAT, 32'h0000_00c0);
        rd(`ILR_OFF_IRQ_EN, 32'h0000_0000);
        wr(`ILR_OFF_IRQ_MASK, 32'hffff_ffff);
        rd(`ILR_OFF_IRQ_MASK, 32'h8000_0000);
        stop_test();
    end

    // the whole sequence needs about a hundred cycles
    initial
    begin
        repeat (3000) @(posedge pclk);
        err_total++;
        stop_test();
    end
endmodule
